// File: inc/gpb_pkg.sv
// Package with register map, reset values and shared helpers of the port block.
`default_nettype none
package gpb_pkg;
    // Width of the pin group and of each register.
    localparam int unsigned GPB_PORT_W     = 8;
    // Avalon data width and word address width.
    localparam int unsigned GPB_BUS_W      = 32;
    localparam int unsigned GPB_ADDR_W     = 2;
    localparam int unsigned GPB_BE_W       = 4;

    // Byte offsets of the registers on the bus.
    localparam logic [7:0] GPB_OFS_DATA    = 8'h00;
    localparam logic [7:0] GPB_OFS_DIR     = 8'h04;
    localparam logic [7:0] GPB_OFS_LEVEL   = 8'h08;
    localparam logic [7:0] GPB_OFS_STATUS  = 8'h0c;

    // Bit position of the dropped-lane flag in the status register.
    localparam int unsigned GPB_STAT_DROP  = 0;

    // Values after reset.
    localparam logic [7:0] GPB_RST_DATA    = 8'h00;
    localparam logic [7:0] GPB_RST_DIR     = 8'h00;
    localparam logic [7:0] GPB_RST_LEVEL   = 8'h00;

    // Value every read of the direction register returns.
    localparam logic [7:0] GPB_DIR_READ    = 8'hff;

    // Byte lane that carries an eight-bit register.
    localparam logic [3:0] GPB_LANE_REG    = 4'h1;

    // Bus answer states, Gray coded along the request path.
    typedef enum logic [1:0] {
        GPB_IDLE   = 2'b00,
        GPB_ANSWER = 2'b01
    } gpb_bus_state_e;

    // True when the word address selects the register at the given byte offset.
    function automatic logic gpb_hit(input logic [1:0] addr, input logic [7:0] ofs);
        gpb_hit = (addr == ofs[3:2]);
    endfunction : gpb_hit
endpackage : gpb_pkg
`default_nettype wire

// File: hdl/gpb_pin_stage.sv
// Pin stage: samples the pin levels and drives pin outputs from flip-flops.
`default_nettype none
module gpb_pin_stage
    import gpb_pkg::*;
(
    input  wire logic                  ref_clk,     // System clock.
    input  wire logic                  rst_n,       // Synchronous reset, active low.
    input  wire logic [GPB_PORT_W-1:0] pins_in,     // Levels seen on the pins.
    input  wire logic [GPB_PORT_W-1:0] data_bits,   // Stored data bits.
    input  wire logic [GPB_PORT_W-1:0] dir_bits,    // Stored direction bits.
    output logic      [GPB_PORT_W-1:0] level_q,     // Sampled pin levels.
    output logic      [GPB_PORT_W-1:0] pins_out_q,  // Level driven on each pin.
    output logic      [GPB_PORT_W-1:0] pins_oe_n_q  // Low where the pin is driven.
);
    // Pins are synchronous to the clock, so one stage is enough.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            level_q <= GPB_RST_LEVEL;
        end
        else
        begin
            level_q <= pins_in;
        end
    end

    // An output pin drives its data bit; a direction bit of 1 enables the driver.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            pins_out_q  <= GPB_RST_DATA;
            pins_oe_n_q <= ~GPB_RST_DIR;
        end
        else
        begin
            pins_out_q  <= data_bits;
            pins_oe_n_q <= ~dir_bits;
        end
    end
endmodule : gpb_pin_stage
`default_nettype wire

// File: hdl/gpb_readback.sv
// Readback merge: what software sees when it reads the data register.
`default_nettype none
module gpb_readback
    import gpb_pkg::*;
(
    input  wire logic [GPB_PORT_W-1:0] data_bits,  // Stored data bits.
    input  wire logic [GPB_PORT_W-1:0] dir_bits,   // Stored direction bits.
    input  wire logic [GPB_PORT_W-1:0] level_bits, // Sampled pin levels.
    output logic      [GPB_PORT_W-1:0] merged      // Per-bit readback value.
);
    // Each bit picks the stored bit for outputs and the pin level for inputs.
    // A read-modify-write on this value therefore copies pin levels into the
    // data bits of input pins; software should keep its own copy instead.
    always_comb
    begin
        merged = (data_bits & dir_bits)
               | (level_bits & ~dir_bits);
    end
endmodule : gpb_readback
`default_nettype wire

// File: hdl/gpb_port.sv
// Eight-pin I/O port with data and direction registers on an Avalon-MM slave.
`default_nettype none

module gpb_port
    import gpb_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    input  wire logic [GPB_ADDR_W-1:0] avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [GPB_BUS_W-1:0]  avs_writedata,
    input  wire logic [GPB_BE_W-1:0]   avs_byteenable,
    output logic      [GPB_BUS_W-1:0]  avs_readdata,
    output logic                       avs_waitrequest,
    input  wire logic [GPB_PORT_W-1:0] port_pins_in,
    output logic      [GPB_PORT_W-1:0] port_pins_out,
    output logic      [GPB_PORT_W-1:0] port_pins_oe_n
);

    // Stored data bits, one per pin.
    logic [GPB_PORT_W-1:0] port_pin_data_q;
    // Stored direction bits, one per pin; 1 selects output.
    logic [GPB_PORT_W-1:0] port_pin_direction_q;
    // Pin levels sampled once per clock.
    logic [GPB_PORT_W-1:0] level_q;
    // Value the data register presents to a read.
    logic [GPB_PORT_W-1:0] data_readback;
    // Sticky flag: a write carried lanes that the registers cannot hold.
    logic                  lane_drop_q;
    // Bus answer state.
    gpb_bus_state_e        bus_state_q;
    // Next bus answer state.
    gpb_bus_state_e        bus_state_d;
    // Wait request towards the master, and its next value.
    logic                  waitreq_q;
    logic                  waitreq_d;
    // Read data towards the master, and its next value.
    logic [GPB_BUS_W-1:0]  rdata_q;
    logic [GPB_BUS_W-1:0]  rdata_d;
    // A request is pending on the bus.
    logic                  req_valid;
    // The write of the current request takes effect in this cycle.
    logic                  wr_commit;
    // The current write touches the register byte lane.
    logic                  wr_lane_ok;
    // The current write carries lanes above the register byte.
    logic                  wr_lane_extra;
    // Address decode of the pending request.
    logic                  hit_data;
    logic                  hit_dir;
    logic                  hit_level;
    logic                  hit_status;

    // Pin sampling and pin drivers live in their own stage.
    // The pin drivers sit one flop behind the registers and the sampled levels
    // one flop behind the pins, so a write reaches the pins one cycle after it lands.
    gpb_pin_stage u_pin_stage (
        .ref_clk     (ref_clk),
        .rst_n       (rst_n),
        .pins_in     (port_pins_in),
        .data_bits   (port_pin_data_q),
        .dir_bits    (port_pin_direction_q),
        .level_q     (level_q),
        .pins_out_q  (port_pins_out),
        .pins_oe_n_q (port_pins_oe_n)
    );

    // Merge of stored bits and pin levels for the data register read.
    // The merge itself is combinational; the answer flop in the bus
    // machine is what keeps the read data straight from a register.
    gpb_readback u_readback (
        .data_bits  (port_pin_data_q),
        .dir_bits   (port_pin_direction_q),
        .level_bits (level_q),
        .merged     (data_readback)
    );

    // Decode the address once; the same result serves reads and writes.
    // All four words are mapped, so every address selects one register.
    always_comb
    begin
        hit_data   = gpb_hit(avs_address, GPB_OFS_DATA);
        hit_dir    = gpb_hit(avs_address, GPB_OFS_DIR);
        hit_level  = gpb_hit(avs_address, GPB_OFS_LEVEL);
        hit_status = gpb_hit(avs_address, GPB_OFS_STATUS);
    end

    // Read and write are never high together, so either marks a request.
    // A master that raised both would see a read answered and a write
    // committed in the same access.
    always_comb
    begin
        req_valid = avs_read | avs_write;
    end

    // Registers are eight bits wide: only byte lane 0 is ever stored.
    // A wider write keeps its lane 0 byte and loses the rest, which is
    // what the narrow peripheral path did; a loss on data or direction is flagged in status.
    // A write that misses lane 0 altogether stores nothing.
    always_comb
    begin
        wr_lane_ok    = |(avs_byteenable & GPB_LANE_REG);
        wr_lane_extra = |(avs_byteenable & ~GPB_LANE_REG);
    end

    // A write lands at the edge where the master sees waitrequest low.
    // Both sides then agree on the edge at which the new value exists.
    always_comb
    begin
        wr_commit = (bus_state_q == GPB_ANSWER) && avs_write;
    end

    // Bus answer machine.
    // Every request gets exactly one wait cycle: in IDLE waitrequest is high
    // and the read data is captured; in ANSWER waitrequest is low for one
    // cycle and the master completes. This costs one cycle per access but
    // keeps read data and waitrequest straight from flip-flops.
    always_comb
    begin
        bus_state_d = bus_state_q;
        waitreq_d   = waitreq_q;
        rdata_d     = rdata_q;
        case (bus_state_q)
            GPB_IDLE:
            begin
                // Capture the answer now so that it stands with waitrequest low.
                if (req_valid)
                begin
                    bus_state_d = GPB_ANSWER;
                    waitreq_d   = 1'b0;
                    rdata_d     = '0;
                    if (avs_read)
                    begin
                        // Only the selected register fills the low byte; the rest is zero.
                        if (hit_data)
                        begin
                            // Outputs show the stored bit, inputs the pin level.
                            rdata_d[GPB_PORT_W-1:0] = data_readback;
                        end
                        else if (hit_dir)
                        begin
                            // The stored direction cannot be seen from the bus.
                            rdata_d[GPB_PORT_W-1:0] = GPB_DIR_READ;
                        end
                        else if (hit_level)
                        begin
                            // Raw pin levels, whatever each pin's direction.
                            rdata_d[GPB_PORT_W-1:0] = level_q;
                        end
                        else if (hit_status)
                        begin
                            // Only the dropped-lane flag is defined; other bits read zero.
                            rdata_d[GPB_STAT_DROP] = lane_drop_q;
                        end
                        else
                        begin
                            // Unmapped offsets read as zero.
                            rdata_d = '0;
                        end
                    end
                end
                else
                begin
                    // No request: keep waitrequest high so nothing completes.
                    waitreq_d = 1'b1;
                end
            end
            GPB_ANSWER:
            begin
                // The master has taken the answer at this edge; go back.
                // Read data keep standing until the next request is captured.
                bus_state_d = GPB_IDLE;
                waitreq_d   = 1'b1;
            end
            default:
            begin
                // Unused encoding: fall back to idle with a clean answer.
                bus_state_d = GPB_IDLE;
                waitreq_d   = 1'b1;
                rdata_d     = '0;
            end
        endcase
    end

    // Bus state register.
    // This flop gates the write commit; waitreq_q, moved in step with it, tells the master which edge completes.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            bus_state_q <= GPB_IDLE;
        end
        else
        begin
            bus_state_q <= bus_state_d;
        end
    end

    // Waitrequest stays high in reset so no request completes early.
    // A master that holds a request across reset is simply answered later.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            waitreq_q <= 1'b1;
        end
        else
        begin
            waitreq_q <= waitreq_d;
        end
    end

    // Read data register; bits above the register byte read as zero.
    // Holding the last answer between requests keeps the read bus quiet.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            rdata_q <= '0;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    // Data register: a byte write replaces all eight bits, including those
    // of input pins. Those bits do not reach the pins until the pin turns
    // into an output, so a read-modify-write that picked up pin levels can
    // silently change them; software should write from a shadow copy.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            // Data start low, so a pin turned into an output first drives low.
            port_pin_data_q <= GPB_RST_DATA;
        end
        else if (wr_commit && hit_data && wr_lane_ok)
        begin
            // Only lane 0 is stored; a write without it leaves the bits alone.
            port_pin_data_q <= avs_writedata[GPB_PORT_W-1:0];
        end
    end

    // Direction register: written as a whole byte, never read back.
    // Because reads return all ones, a read-modify-write would turn every
    // input into an output; software should write from a shadow copy.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            // Every pin starts as an input, so nothing is driven out of reset.
            port_pin_direction_q <= GPB_RST_DIR;
        end
        else if (wr_commit && hit_dir && wr_lane_ok)
        begin
            // A write without lane 0 leaves the direction alone.
            port_pin_direction_q <= avs_writedata[GPB_PORT_W-1:0];
        end
    end

    // Dropped-lane flag: set by a write to data or direction that carried extra
    // lanes, cleared by writing 1 to its bit. A new drop in the clearing
    // cycle wins, so no event is lost.
    // Any write to data or direction with lanes above lane 0 raises it,
    // even one that misses lane 0 and therefore stores nothing.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            // No lane has been lost yet.
            lane_drop_q <= 1'b0;
        end
        else if (wr_commit && (hit_data || hit_dir) && wr_lane_extra)
        begin
            lane_drop_q <= 1'b1;
        end
        else if (wr_commit && hit_status && wr_lane_ok
                 && avs_writedata[GPB_STAT_DROP])
        begin
            lane_drop_q <= 1'b0;
        end
    end

    // Bus outputs come straight from their registers.
    // Plain assignments keep any logic out of the path after the flops.
    always_comb
    begin
        avs_readdata    = rdata_q;
        avs_waitrequest = waitreq_q;
    end

endmodule : gpb_port
`default_nettype wire

// File: bench/gpb_port_chk.sv
// Checker of the port's bus answer, pin outputs and register readback.
`default_nettype none
module gpb_port_chk
    import gpb_pkg::*;
(
    input wire logic                  ref_clk,
    input wire logic                  rst_n,
    input wire logic [GPB_ADDR_W-1:0] avs_address,
    input wire logic                  avs_read,
    input wire logic                  avs_write,
    input wire logic [GPB_BUS_W-1:0]  avs_writedata,
    input wire logic [GPB_BE_W-1:0]   avs_byteenable,
    input wire logic [GPB_BUS_W-1:0]  avs_readdata,
    input wire logic                  avs_waitrequest,
    input wire logic [GPB_PORT_W-1:0] port_pins_out,
    input wire logic [GPB_PORT_W-1:0] port_pins_oe_n
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    // A request completes at the edge where waitrequest is seen low.
    wire logic wr_ok = avs_write && !avs_waitrequest;
    wire logic rd_ok = avs_read && !avs_waitrequest;
    a_out_data: assert property (wr_ok && avs_byteenable[0] && avs_address == 2'd0
        |-> ##2 port_pins_out == $past(avs_writedata[7:0], 2))
        else $error("pin outputs do not follow the written data");
    a_oe_dir: assert property (wr_ok && avs_byteenable[0] && avs_address == 2'd1
        |-> ##2 port_pins_oe_n == ~$past(avs_writedata[7:0], 2))
        else $error("pin enables do not follow the written direction");
    // A write without the low lane must leave both pin buses alone.
    a_lane_hold: assert property (wr_ok && !avs_byteenable[0]
        |-> ##2 $stable(port_pins_out) && $stable(port_pins_oe_n))
        else $error("write without the low lane changed the pins");
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_dir_ones: assert property (rd_ok && avs_address == 2'd1 |-> avs_readdata[7:0] == 8'hff)
        else $error("direction read did not return all ones");
    a_upper_zero: assert property (rd_ok |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read lanes not zero");
    // Reset is checked while it is applied, so this one is never disabled.
    a_rst_quiet: assert property (disable iff (1'b0) !rst_n
        |=> port_pins_oe_n == 8'hff && port_pins_out == 8'h00 && avs_waitrequest)
        else $error("pins or bus not quiet under reset");
    c_dir_write: cover property (wr_ok && avs_address == 2'd1);
    c_data_read: cover property (rd_ok && avs_address == 2'd0);
    c_lane_drop: cover property (wr_ok && avs_byteenable == 4'hf);
endmodule : gpb_port_chk
bind gpb_port gpb_port_chk u_chk (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .port_pins_out(port_pins_out),
    .port_pins_oe_n(port_pins_oe_n)
);
`default_nettype wire

// File: bench/gpb_pin_model.sv
// Model of the circuitry outside the pins.
`default_nettype none
module gpb_pin_model
    import gpb_pkg::*;
(
    input  wire logic [GPB_PORT_W-1:0] pins_out,   // Level the port drives.
    input  wire logic [GPB_PORT_W-1:0] pins_oe_n,  // Low where the port drives.
    input  wire logic [GPB_PORT_W-1:0] ext_level,  // Level the outside drives.
    output logic      [GPB_PORT_W-1:0] pins_in     // Resolved wire level.
);
    // A driven pin shows the port's level, an undriven one the outside level.
    assign pins_in = (pins_out & ~pins_oe_n) | (ext_level & pins_oe_n);
endmodule : gpb_pin_model
`default_nettype wire

// File: bench/tb_gpb_port.sv
// Testbench of the eight-pin port: bus tasks and scenarios.
`default_nettype none
module tb_gpb_port
    import gpb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [1:0] AD = 2'd0;  // Data register word.
    localparam logic [1:0] AC = 2'd1;  // Direction register word.
    localparam logic [1:0] AL = 2'd2;  // Pin level register word.
    localparam logic [1:0] AS = 2'd3;  // Status register word.
    logic        ref_clk        = 1'b0;
    logic        rst_n          = 1'b0;
    logic [1:0]  avs_address    = 2'h0;
    logic        avs_read       = 1'b0;
    logic        avs_write      = 1'b0;
    logic [31:0] avs_writedata  = 32'h0;
    logic [3:0]  avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [7:0]  pins_in;
    logic [7:0]  pins_out;
    logic [7:0]  pins_oe_n;
    logic [7:0]  ext_level      = 8'h00;
    int          n_fail         = 0;
    int          total_checks   = 0;
    always #10 ref_clk = ~ref_clk;
    gpb_port dut (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .port_pins_in(pins_in),
        .port_pins_out(pins_out), .port_pins_oe_n(pins_oe_n));
    gpb_pin_model u_pins (.pins_out(pins_out), .pins_oe_n(pins_oe_n),
        .ext_level(ext_level), .pins_in(pins_in));
    task automatic print_verdict();
        $display("checks=%0d failures=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One bus cycle; b2b launches right after the last edge of a read/write of the other kind.
    task automatic bus(input logic wr, input logic [1:0] a, input logic [31:0] d,
                       input logic [3:0] be, input bit b2b, output logic [31:0] rd);
        if (!b2b)
            @(posedge ref_clk);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        // Only this kind's strobe is touched, so a back-to-back call never
        // assigns the strobe that the previous call has just released.
        if (wr)
            avs_write <= 1'b1;
        else
            avs_read  <= 1'b1;
        // Wait however long the answer takes; only the watchdog ends a hang.
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge ref_clk);
        rd = avs_readdata;
        if (wr)
            avs_write <= 1'b0;
        else
            avs_read  <= 1'b0;
    endtask : bus
    task automatic wr(input logic [1:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] x;
        bus(1'b1, a, d, be, 1'b0, x);
    endtask : wr
    task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp, input bit b2b);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, 4'h1, b2b, x);
        chk(x, {24'h0, exp});
    endtask : rd_chk
    // Pins move one edge after the register, so wait two edges before looking.
    task automatic pin_chk(input logic [7:0] out, input logic [7:0] oe_n);
        repeat (2) @(posedge ref_clk);
        #1;
        chk({24'h0, pins_out}, {24'h0, out});
        chk({24'h0, pins_oe_n}, {24'h0, oe_n});
    endtask : pin_chk
    task automatic t_reset();
        ext_level <= 8'ha5;
        pin_chk(8'h00, 8'hff);
        rd_chk(AC, 8'hff, 1'b0);
        rd_chk(AD, 8'ha5, 1'b0);
    endtask : t_reset
    // Bit set done as read-modify-write picks up input pin levels.
    task automatic t_bit_set();
        ext_level <= 8'h40;
        wr(AC, 32'h3f, 4'h1);
        wr(AD, 32'h80, 4'h1);
        pin_chk(8'h80, 8'hc0);
        rd_chk(AD, 8'h40, 1'b0);
        wr(AD, 32'h41, 4'h1);
        pin_chk(8'h41, 8'hc0);
        wr(AD, 32'h83, 4'h1);
        rd_chk(AD, 8'h43, 1'b1);
    endtask : t_bit_set
    // Bit clear on the write-only direction register turns inputs into outputs.
    task automatic t_dir_clear();
        wr(AC, 32'h3f, 4'h1);
        rd_chk(AC, 8'hff, 1'b1);
        wr(AC, 32'hfe, 4'h1);
        pin_chk(8'h83, 8'h01);
        wr(AC, 32'h3e, 4'h1);
        pin_chk(8'h83, 8'hc1);
    endtask : t_dir_clear
    task automatic t_word();
        wr(AC, 32'hff, 4'h1);
        wr(AD, 32'h1234_5677, 4'hf);
        rd_chk(AD, 8'h77, 1'b1);
        rd_chk(AS, 8'h01, 1'b0);
        wr(AS, 32'h1, 4'h1);
        rd_chk(AS, 8'h00, 1'b0);
        wr(AD, 32'h00, 4'h2);
        pin_chk(8'h77, 8'h00);
        rd_chk(AL, 8'h77, 1'b0);
    endtask : t_word
    initial
    begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_bit_set();
        t_dir_clear();
        t_word();
        print_verdict();
    end
    // A hang runs into this limit well after the scenarios should be over.
    initial
    begin
        repeat (2000) @(posedge ref_clk);
        n_fail++;
        print_verdict();
    end
endmodule : tb_gpb_port
`default_nettype wire
